// [src/module_control_pin_logic.sv]
`timescale 1ns/10ps
`include "pin_ctrl_defines.svh"

// Summary of operation
// RULE1 - tamper loop break raises software flag
// RULE2 - tamper check runs in every power state
// RULE3 - power pin low overrides everything, hard reset
// RULE4 - power pin high enables regulators, boots
// RULE5 - power pin low disables regulators, shutdown
// RULE6 - host holds pin low 100 ms
// RULE7 - host never leaves power pin floating
// RULE8 - alarm: hiZ deep0/1, low deep2, high active
// RULE9 - debug port routed to modem or mcu
// RULE10 - debug route default from select pin
// RULE11 - select pin weakly pulled low
// RULE12 - test clear high enters debug mode
// RULE13 - debug pins dedicated, never multiplexed
// RULE14 - converter and serial pins selectable gpio
// RULE15 - wake input high wakes, low allows sleep
// RULE16 - tamper flag sticky until software acknowledge
module module_control_pin_logic
   import pin_ctrl_pkg::*;
#(
   parameter int unsigned RESET_LOW_MIN_CYCLES =
      `CTL_RESET_LOW_MS * 1000 * `CTL_CLK_MHZ
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic power_hold_in,
   input wire logic tamper_loop_in,
   input wire logic sleep_exit_in,
   input wire logic debug_sel_in,
   input wire logic debug_tap_test_clear,
   input wire logic [5:0] gpio_pad_i,
   input wire logic tamper_ack,
   input wire sleep_level_t level_req,
   input wire gpio_ctl_t gpio_ctl,
   output logic tamper_loop_out,
   output logic tamper_flag,
   output logic regulator_en,
   output logic hard_reset,
   output logic short_low_pulse,
   output logic host_alarm_out,
   output logic host_alarm_oe,
   output logic debug_route_mcu,
   output logic debug_mode,
   output logic debug_pulldown_en,
   output logic mcu_wake,
   output logic [5:0] gpio_pad_o,
   output logic [5:0] gpio_pad_oe,
   output logic [5:0] gpio_in_val
);

   // ----------------------------------------------------------------
   // constants and helpers
   // ----------------------------------------------------------------
   localparam logic [23:0] LOW_MIN = RESET_LOW_MIN_CYCLES[23:0];

   localparam ctl_state_t STATE_RST = '{
      pstate: PWR_OFF,
      hard_reset: `CTL_HARD_RESET_RST,
      pulldown_en: `CTL_PULLDOWN_RST,
      default: '0
   };

   // {oe, level} of the alarm pin for a power level
   function automatic logic [1:0] alarm_drive(input sleep_level_t lvl);
      case (lvl)
         LVL_ACTIVE: alarm_drive = 2'h3;
         LVL_DEEP2: alarm_drive = 2'h2;
         default: alarm_drive = 2'h0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   pin_sync_t pins_raw;
   pin_sync_t pins;
   ctl_state_t state_reg;
   ctl_state_t state_next;
   logic [1:0] alarm_sel;
   logic loop_check;

   assign pins_raw = '{
      power_pin: power_hold_in,
      tamper_in: tamper_loop_in,
      sleep_exit: sleep_exit_in,
      debug_sel: debug_sel_in,
      tap_clear: debug_tap_test_clear,
      gpio: gpio_pad_i
   };

   pin_sync_bank u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .clk_en(clk_en),
      .pins_async(pins_raw),
      .pins_sync(pins)
   );

   assign alarm_sel = alarm_drive(level_req);
   assign loop_check = (state_reg.tick == `CTL_LOOP_HALF);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;

      // tamper loop: slow toggle so a short to either rail is seen too
      state_next.tick = state_reg.tick + 4'h1;
      if (loop_check) begin
         state_next.loop_drive = ~state_reg.loop_drive;
      end
      if (tamper_ack) begin
         state_next.tamper_flag = 1'b0; // RULE16
      end
      // set wins over acknowledge; no power-state gating here
      if (loop_check && (pins.tamper_in != state_reg.loop_drive)) begin
         state_next.tamper_flag = 1'b1; // RULE1 RULE2
      end

      // power sequencer
      case (state_reg.pstate)
         PWR_OFF: begin
            if (pins.power_pin) begin
               state_next.pstate = PWR_RAMP; // RULE4
               state_next.regulator_en = 1'b1;
               state_next.ramp_cnt = 8'h00;
               state_next.low_short = (state_reg.low_cnt < LOW_MIN);
            end
         end
         PWR_RAMP: begin
            state_next.ramp_cnt = state_reg.ramp_cnt + 8'h01;
            if (state_reg.ramp_cnt == `CTL_RAMP_CYCLES - 8'h01) begin
               state_next.pstate = PWR_RUN;
               state_next.hard_reset = 1'b0;
               // route latched once per boot from the strap level
               state_next.debug_route_mcu = pins.debug_sel; // RULE9 RULE10
            end
         end
         PWR_RUN: begin
            state_next.hard_reset = 1'b0;
         end
         default: begin
            state_next.pstate = PWR_OFF;
         end
      endcase

      // pin low beats every other branch above
      if (!pins.power_pin) begin
         state_next.pstate = PWR_OFF; // RULE3
         state_next.regulator_en = 1'b0; // RULE5
         state_next.hard_reset = 1'b1; // RULE3
         if (state_reg.low_cnt != `CTL_LOW_CNT_MAX) begin
            state_next.low_cnt = state_reg.low_cnt + 24'h000001;
         end
      end else if (state_reg.pstate != PWR_OFF) begin
         state_next.low_cnt = 24'h000000;
      end

      // alarm pin only speaks while the module is up
      if (state_next.pstate == PWR_RUN) begin
         state_next.alarm_oe = alarm_sel[1]; // RULE8
         state_next.alarm_out = alarm_sel[0]; // RULE8
      end else begin
         state_next.alarm_oe = 1'b0;
         state_next.alarm_out = 1'b0;
      end

      state_next.debug_mode = pins.tap_clear; // RULE12
      state_next.mcu_wake = pins.sleep_exit; // RULE15
      // pull-downs stay on; undriven select means low routing
      state_next.pulldown_en = 1'b1; // RULE11

      // only these six pads are shared; debug pins never pass here
      for (int i = 0; i < `CTL_GPIO_N; i++) begin
         if (gpio_ctl.sel[i]) begin
            state_next.pad_o[i] = gpio_ctl.out_val[i]; // RULE14
            state_next.pad_oe[i] = gpio_ctl.out_en[i]; // RULE14
         end else begin
            state_next.pad_o[i] = gpio_ctl.alt_val[i]; // RULE13
            state_next.pad_oe[i] = gpio_ctl.alt_en[i];
         end
      end
      state_next.gpio_in = pins.gpio;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= STATE_RST;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   assign tamper_loop_out = state_reg.loop_drive;
   assign tamper_flag = state_reg.tamper_flag;
   assign regulator_en = state_reg.regulator_en;
   assign hard_reset = state_reg.hard_reset;
   assign short_low_pulse = state_reg.low_short;
   assign host_alarm_out = state_reg.alarm_out;
   assign host_alarm_oe = state_reg.alarm_oe;
   assign debug_route_mcu = state_reg.debug_route_mcu;
   assign debug_mode = state_reg.debug_mode;
   assign debug_pulldown_en = state_reg.pulldown_en;
   assign mcu_wake = state_reg.mcu_wake;
   assign gpio_pad_o = state_reg.pad_o;
   assign gpio_pad_oe = state_reg.pad_oe;
   assign gpio_in_val = state_reg.gpio_in;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   property p_tamper_set;
      clk_en && loop_check && (pins.tamper_in != state_reg.loop_drive)
         |=> tamper_flag;
   endproperty
   a_tamper_set: assert property (p_tamper_set) // RULE1
      else $error("loop break not flagged");

   property p_tamper_deep;
      clk_en && (level_req != LVL_ACTIVE) && loop_check &&
         (pins.tamper_in != state_reg.loop_drive) ##1 1'b1
         |-> tamper_flag;
   endproperty
   a_tamper_deep: assert property (p_tamper_deep) // RULE2
      else $error("loop break missed in deep sleep");

   property p_tamper_sticky;
      tamper_flag && !(clk_en && tamper_ack) |=> tamper_flag;
   endproperty
   a_tamper_sticky: assert property (p_tamper_sticky) // RULE16
      else $error("tamper flag dropped without ack");

   property p_pin_low_override;
      clk_en && !pins.power_pin |=> hard_reset && !host_alarm_oe;
   endproperty
   a_pin_low_override: assert property (p_pin_low_override) // RULE3
      else $error("power pin low did not force reset");

   property p_pin_low_off;
      clk_en && !pins.power_pin |=> !regulator_en;
   endproperty
   a_pin_low_off: assert property (p_pin_low_off) // RULE5
      else $error("regulators on with power pin low");

   property p_pin_high_up;
      clk_en && pins.power_pin && (state_reg.pstate == PWR_OFF)
         |=> regulator_en && hard_reset;
   endproperty
   a_pin_high_up: assert property (p_pin_high_up) // RULE4
      else $error("power up not started");

   property p_alarm_active;
      clk_en && pins.power_pin && (state_reg.pstate == PWR_RUN) &&
         (level_req == LVL_ACTIVE) |=> host_alarm_oe && host_alarm_out;
   endproperty
   a_alarm_active: assert property (p_alarm_active) // RULE8
      else $error("alarm not high while active");

   property p_alarm_deep01;
      clk_en && ((level_req == LVL_DEEP0) || (level_req == LVL_DEEP1))
         |=> !host_alarm_oe;
   endproperty
   a_alarm_deep01: assert property (p_alarm_deep01) // RULE8
      else $error("alarm driven in deep level 0 or 1");

   property p_route_hold;
      state_reg.pstate != PWR_RAMP |=> $stable(debug_route_mcu);
   endproperty
   a_route_hold: assert property (p_route_hold) // RULE10
      else $error("debug route changed outside boot");

   property p_debug_mode;
      clk_en && pins.tap_clear |=> debug_mode;
   endproperty
   a_debug_mode: assert property (p_debug_mode) // RULE12
      else $error("debug mode not entered");

   property p_wake_follow;
      clk_en |=> (mcu_wake == $past(pins.sleep_exit));
   endproperty
   a_wake_follow: assert property (p_wake_follow) // RULE15
      else $error("wake output does not follow wake pin");

   property p_gpio_mux;
      clk_en |=> (gpio_pad_o == $past((gpio_ctl.sel & gpio_ctl.out_val) |
         (~gpio_ctl.sel & gpio_ctl.alt_val)));
   endproperty
   a_gpio_mux: assert property (p_gpio_mux) // RULE14
      else $error("pad output not taken from selected source");

   c_tamper: cover property (clk_en && !tamper_flag ##1 tamper_flag);
   c_run: cover property (state_reg.pstate == PWR_RUN);
   c_alarm_low: cover property (host_alarm_oe && !host_alarm_out);
   c_route_mcu: cover property (debug_route_mcu && !hard_reset);

endmodule // module_control_pin_logic

// [src/pin_ctrl_defines.svh]
`ifndef PIN_CTRL_DEFINES_SVH
`define PIN_CTRL_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CTL_CLK_MHZ 100
`define CTL_RESET_LOW_MS 100
`define CTL_RAMP_CYCLES 8'h10
`define CTL_LOOP_HALF 4'hF

// ----------------------------------------------------------------
// widths and counter limits
// ----------------------------------------------------------------
`define CTL_GPIO_N 6
`define CTL_SYNC_W 11
`define CTL_LOW_CNT_W 24
`define CTL_LOW_CNT_MAX 24'hFFFFFF

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTL_PULLDOWN_RST 1'b1
`define CTL_HARD_RESET_RST 1'b1

`endif

// [src/pin_ctrl_pkg.sv]
package pin_ctrl_pkg;

   typedef enum logic [1:0] {
      PWR_OFF  = 2'h0,
      PWR_RAMP = 2'h1,
      PWR_RUN  = 2'h3
   } pwr_state_t;

   typedef enum logic [1:0] {
      LVL_ACTIVE = 2'h0,
      LVL_DEEP0  = 2'h1,
      LVL_DEEP1  = 2'h2,
      LVL_DEEP2  = 2'h3
   } sleep_level_t;

   typedef struct packed {
      logic power_pin;
      logic tamper_in;
      logic sleep_exit;
      logic debug_sel;
      logic tap_clear;
      logic [5:0] gpio;
   } pin_sync_t;

   typedef struct packed {
      logic [5:0] sel;
      logic [5:0] out_val;
      logic [5:0] out_en;
      logic [5:0] alt_val;
      logic [5:0] alt_en;
   } gpio_ctl_t;

   typedef struct packed {
      logic [10:0] stage1;
      logic [10:0] stage2;
   } sync_state_t;

   typedef struct packed {
      pwr_state_t pstate;
      logic [23:0] low_cnt;
      logic low_short;
      logic [7:0] ramp_cnt;
      logic [3:0] tick;
      logic loop_drive;
      logic tamper_flag;
      logic regulator_en;
      logic hard_reset;
      logic alarm_out;
      logic alarm_oe;
      logic debug_route_mcu;
      logic debug_mode;
      logic mcu_wake;
      logic pulldown_en;
      logic [5:0] pad_o;
      logic [5:0] pad_oe;
      logic [5:0] gpio_in;
   } ctl_state_t;

endpackage

// [src/pin_sync_bank.sv]
`timescale 1ns/10ps
`include "pin_ctrl_defines.svh"

module pin_sync_bank
   import pin_ctrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [`CTL_SYNC_W-1:0] pins_async,
   output logic [`CTL_SYNC_W-1:0] pins_sync
);

   sync_state_t state_reg;
   sync_state_t state_next;

   // first stage feeds only the second stage
   always_comb begin
      state_next = state_reg;
      state_next.stage1 = pins_async;
      state_next.stage2 = state_reg.stage1;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= '0;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   assign pins_sync = state_reg.stage2;

endmodule // pin_sync_bank

// [test/host_ctrl_model.sv]
`timescale 1ns/10ps

module host_ctrl_model (
   input wire logic clk_sys,
   input wire logic tamper_loop_out,
   output logic power_hold_in,
   output logic tamper_loop_in,
   output logic sleep_exit_in,
   output logic debug_sel_in,
   output logic debug_tap_test_clear,
   output logic [5:0] gpio_pad_i
);
   logic loop_closed;
   logic strap_driven;
   logic strap_val;
   int unsigned low_cycles;

   initial begin
      power_hold_in = 1'b0;
      loop_closed = 1'b1;
      strap_driven = 1'b0;
      strap_val = 1'b0;
      sleep_exit_in = 1'b0;
      debug_tap_test_clear = 1'b0;
      gpio_pad_i = 6'h00;
      low_cycles = 0;
   end

   // open loop floats: show the inverse so the break is always seen
   assign tamper_loop_in = loop_closed ? tamper_loop_out : ~tamper_loop_out;
   // released strap falls to its pull-down
   assign debug_sel_in = strap_driven ? strap_val : 1'b0;

   always @(posedge clk_sys) begin
      low_cycles <= power_hold_in ? 0 : low_cycles + 1;
   end

   task automatic power_drop();
      @(negedge clk_sys);
      power_hold_in = 1'b0;
   endtask

   // a short min_low is only asked for on purpose
   task automatic power_rise(input int unsigned min_low);
      @(negedge clk_sys);
      while (low_cycles < min_low) @(negedge clk_sys);
      power_hold_in = 1'b1;
   endtask

   task automatic strap_set(input logic drive, input logic val);
      @(negedge clk_sys);
      strap_driven = drive;
      strap_val = val;
   endtask

   task automatic loop_set(input logic closed);
      @(negedge clk_sys);
      loop_closed = closed;
   endtask

   task automatic misc_set(input logic w, input logic tc, input logic [5:0] p);
      @(negedge clk_sys);
      sleep_exit_in = w;
      debug_tap_test_clear = tc;
      gpio_pad_i = p;
   endtask
endmodule // host_ctrl_model

// [test/tb_module_control_pin_logic.sv]
`timescale 1ns/10ps

module tb_module_control_pin_logic
   import pin_ctrl_pkg::*;
;
   localparam int unsigned LOW_MIN = 50;
   localparam logic [27:0] M_TAMP = 28'h8000000;
   localparam logic [27:0] M_REG = 28'h4000000;
   localparam logic [27:0] M_HARD = 28'h2000000;
   localparam logic [27:0] M_SHORT = 28'h1000000;
   localparam logic [27:0] M_AOUT = 28'h0800000;
   localparam logic [27:0] M_AOE = 28'h0400000;
   localparam logic [27:0] M_ROUTE = 28'h0200000;

   typedef struct {int due; logic [27:0] mask; logic [27:0] exp;} note_t;

   logic clk_sys, reset, clk_en, tamper_ack;
   logic power_hold_in, tamper_loop_in, sleep_exit_in, debug_sel_in;
   logic debug_tap_test_clear, tamper_loop_out, tamper_flag, regulator_en;
   logic hard_reset, short_low_pulse, host_alarm_out, host_alarm_oe;
   logic debug_route_mcu, debug_mode, debug_pulldown_en, mcu_wake;
   logic [5:0] gpio_pad_i, gpio_pad_o, gpio_pad_oe, gpio_in_val;
   sleep_level_t level_req;
   gpio_ctl_t gpio_ctl;
   logic [27:0] obs;
   note_t notes[$];
   int cyc = 0;
   int n_mismatch = 0;
   int tests_run = 0;

   assign obs = {tamper_flag, regulator_en, hard_reset, short_low_pulse,
      host_alarm_out, host_alarm_oe, debug_route_mcu, debug_mode,
      debug_pulldown_en, mcu_wake, gpio_pad_o, gpio_pad_oe, gpio_in_val};

   module_control_pin_logic #(.RESET_LOW_MIN_CYCLES(LOW_MIN)) i_dut (
      .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
      .power_hold_in(power_hold_in), .tamper_loop_in(tamper_loop_in),
      .sleep_exit_in(sleep_exit_in), .debug_sel_in(debug_sel_in),
      .debug_tap_test_clear(debug_tap_test_clear),
      .gpio_pad_i(gpio_pad_i), .tamper_ack(tamper_ack),
      .level_req(level_req), .gpio_ctl(gpio_ctl),
      .tamper_loop_out(tamper_loop_out), .tamper_flag(tamper_flag),
      .regulator_en(regulator_en), .hard_reset(hard_reset),
      .short_low_pulse(short_low_pulse), .host_alarm_out(host_alarm_out),
      .host_alarm_oe(host_alarm_oe), .debug_route_mcu(debug_route_mcu),
      .debug_mode(debug_mode), .debug_pulldown_en(debug_pulldown_en),
      .mcu_wake(mcu_wake), .gpio_pad_o(gpio_pad_o),
      .gpio_pad_oe(gpio_pad_oe), .gpio_in_val(gpio_in_val));

   host_ctrl_model i_host (
      .clk_sys(clk_sys), .tamper_loop_out(tamper_loop_out),
      .power_hold_in(power_hold_in), .tamper_loop_in(tamper_loop_in),
      .sleep_exit_in(sleep_exit_in), .debug_sel_in(debug_sel_in),
      .debug_tap_test_clear(debug_tap_test_clear), .gpio_pad_i(gpio_pad_i));

   // ------------------------------------------------------------
   // clock, checking and verdict
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) cyc <= cyc + 1;

   task automatic check(input logic [27:0] seen, input logic [27:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // notes fall due at a negedge, when registered outputs have settled
   always @(negedge clk_sys) begin
      for (int i = notes.size() - 1; i >= 0; i--) begin
         if (notes[i].due <= cyc) begin
            check(obs & notes[i].mask, notes[i].exp);
            notes.delete(i);
         end
      end
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      n_mismatch++;
      print_verdict();
   end

   // ------------------------------------------------------------
   // driver helpers
   // ------------------------------------------------------------
   task automatic note(input int d, input logic [27:0] m, input logic [27:0] e);
      notes.push_back('{cyc + d, m, e});
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic boot(input int unsigned min_low, input logic route);
      i_host.power_rise(min_low);
      note(3, M_REG | M_HARD, M_REG | M_HARD);
      note(4, M_SHORT, 28'h0);
      note(18, M_HARD, M_HARD);
      note(19, M_HARD | M_ROUTE, route ? M_ROUTE : 28'h0);
      wait_cyc(21);
   endtask

   task automatic tamper_run();
      int n;
      i_host.loop_set(1'b0);
      n = 0;
      while (tamper_flag !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      check(28'(tamper_flag), 28'h1);
      if (n >= 40) print_verdict();
      i_host.loop_set(1'b1);
      wait_cyc(40);
      note(1, M_TAMP, M_TAMP);
      wait_cyc(1);
      tamper_ack = 1'b1;
      note(1, M_TAMP, 28'h0);
      wait_cyc(1);
      tamper_ack = 1'b0;
      wait_cyc(40);
      note(1, M_TAMP, 28'h0);
      wait_cyc(2);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      sleep_level_t lv;
      logic strap, w, tc;
      logic [5:0] p, po, poe;
      void'($urandom(83));
      reset = 1'b1;
      clk_en = 1'b1;
      tamper_ack = 1'b0;
      level_req = LVL_ACTIVE;
      gpio_ctl = '0;
      wait_cyc(2);
      note(1, 28'hFFFFFFF, M_HARD | 28'h0080000);
      wait_cyc(1);
      reset = 1'b0;
      // loop drive first flips 16 enabled edges after release
      wait_cyc(15);
      check(28'(tamper_loop_out), 28'h0);
      wait_cyc(1);
      check(28'(tamper_loop_out), 28'h1);
      // loop stays intact while the module is off
      wait_cyc(24);
      note(1, M_TAMP, 28'h0);
      tamper_run();
      strap = 1'($urandom);
      i_host.strap_set(1'b1, strap);
      boot(LOW_MIN + 8, strap);
      for (int k = 0; k < 4; k++) begin
         lv = sleep_level_t'(2'(k));
         @(negedge clk_sys);
         level_req = lv;
         if (lv == LVL_ACTIVE) note(2, M_AOE | M_AOUT, M_AOE | M_AOUT);
         else if (lv == LVL_DEEP2) note(2, M_AOE | M_AOUT, M_AOE);
         else note(2, M_AOE, 28'h0);
         wait_cyc(3);
      end
      repeat (8) begin
         w = 1'($urandom);
         tc = 1'($urandom);
         p = 6'($urandom);
         i_host.misc_set(w, tc, p);
         gpio_ctl = 30'($urandom);
         po = (gpio_ctl.sel & gpio_ctl.out_val) | (~gpio_ctl.sel & gpio_ctl.alt_val);
         poe = (gpio_ctl.sel & gpio_ctl.out_en) | (~gpio_ctl.sel & gpio_ctl.alt_en);
         note(1, 28'h003FFC0, {10'h0, po, poe, 6'h0});
         note(3, 28'h01C003F, {7'h0, tc, 1'b1, w, 12'h0, p});
         wait_cyc(4);
      end
      // enable low: fresh pins and controls must not reach any output
      clk_en = 1'b0;
      gpio_ctl = ~gpio_ctl;
      i_host.misc_set(~w, ~tc, ~p);
      wait_cyc(3);
      note(1, 28'h01FFFFF, {7'h0, tc, 1'b1, w, po, poe, p});
      wait_cyc(1);
      clk_en = 1'b1;
      po = (gpio_ctl.sel & gpio_ctl.out_val) |
         (~gpio_ctl.sel & gpio_ctl.alt_val);
      poe = (gpio_ctl.sel & gpio_ctl.out_en) |
         (~gpio_ctl.sel & gpio_ctl.alt_en);
      note(3, 28'h01FFFFF, {7'h0, ~tc, 1'b1, ~w, po, poe, ~p});
      wait_cyc(4);
      level_req = LVL_DEEP2;
      tamper_run();
      level_req = LVL_ACTIVE;
      // short low pulse, then a drop in mid-ramp
      i_host.power_drop();
      note(3, M_REG | M_HARD | M_AOE, M_HARD);
      i_host.power_rise(5);
      note(4, M_REG | M_HARD | M_SHORT, M_REG | M_HARD | M_SHORT);
      wait_cyc(8);
      i_host.power_drop();
      note(3, M_REG | M_HARD, M_HARD);
      i_host.strap_set(1'b0, 1'b0);
      boot(LOW_MIN + 8, 1'b0);
      wait_cyc(5);
      print_verdict();
   end
endmodule // tb_module_control_pin_logic
